/* File: logic/mie_exec.sv */
`timescale 1ns/1ns
`default_nettype none
module mie_exec import mie_pkg::*; #(
	parameter int PC_WIDTH    = 13,
	parameter int STACK_DEPTH = 8,
	parameter int DMEM_DEPTH  = 224
) (
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                RSTN,
	// instruction feed
	input  wire logic                INSTR_VALID,
	input  wire logic [15:0]         INSTR,
	output logic                     READY,
	output logic                     DISCARD,
	output logic      [PC_WIDTH-1:0] PC,
	// call path into the return stack
	input  wire logic                PUSH,
	input  wire logic [PC_WIDTH-1:0] PUSH_PC,
	// register port
	input  wire logic [7:0]          ADDR,
	input  wire logic [7:0]          WR_DATA,
	input  wire logic                WR,
	input  wire logic                RD,
	output logic      [7:0]          RD_DATA,
	// core state
	output logic      [7:0]          ACC,
	output logic                     FLAG_C,
	output logic                     FLAG_AC,
	output logic                     FLAG_Z,
	output logic                     FLAG_OV,
	output logic                     GIE
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	mie_state_t state;
	mie_state_t next_state;
	logic       hold;
	logic       skip_pending;
	logic       unknown;
	logic [7:0] dmem [0:DMEM_DEPTH-1];

	// ------------------------------------------------------------
	// instruction decode
	// ------------------------------------------------------------
	wire [7:0] opc  = INSTR[15:8];
	wire [7:0] opnd = INSTR[7:0];
	wire       take = (state == ST_EXEC) && INSTR_VALID && !hold;

	wire is_nop   = opc == OP_NO_OPERATION;
	wire is_ld_m  = opc == OP_COPY_MEM_TO_ACC;
	wire is_ld_x  = opc == OP_COPY_IMM_TO_ACC;
	wire is_st_m  = opc == OP_COPY_ACC_TO_MEM;
	wire is_or_m  = opc == OP_DISJ_MEM_TO_ACC;
	wire is_or_x  = opc == OP_DISJ_IMM_TO_ACC;
	wire is_orm   = opc == OP_DISJ_TO_MEMORY;
	wire is_ret   = opc == OP_SUBROUTINE_EXIT;
	wire is_retv  = opc == OP_EXIT_WITH_VALUE;
	wire is_interrupt_exit  = opc == OP_INTERRUPT_EXIT;
	wire is_rl    = opc == OP_ROTATE_LEFT_IN_PLACE;
	wire is_rla   = opc == OP_ROTATE_LEFT_TO_ACC;
	wire is_rlc   = opc == OP_ROTATE_LEFT_VIA_CARRY;
	wire is_rotate_left_via_carry_to_acc  = opc == OP_ROTATE_LEFT_VC_TO_ACC;
	wire is_rr    = opc == OP_ROTATE_RIGHT_IN_PLACE;
	wire is_rra   = opc == OP_ROTATE_RIGHT_TO_ACC;
	wire is_rrc   = opc == OP_ROTATE_RIGHT_VIA_CARRY;
	wire is_rotate_right_via_carry_to_acc  = opc == OP_ROTATE_RIGHT_VC_TO_ACC;
	wire is_sbc   = opc == OP_SUBTRACT_WITH_BORROW_TO_ACC;
	wire is_subtract_with_borrow_to_memory  = opc == OP_SUBTRACT_WITH_BORROW_TO_MEMORY;
	wire is_dsz   = opc == OP_DECREMENT_SKIP_IF_ZERO;
	wire is_dsza  = opc == OP_DECREMENT_SKIP_IF_ZERO_TO_ACC;

	wire is_exit  = is_ret | is_retv | is_interrupt_exit;
	wire is_known = opc <= OP_DECREMENT_SKIP_IF_ZERO_TO_ACC;

	// ------------------------------------------------------------
	// instruction groups
	// ------------------------------------------------------------
	// paired opcodes share one alu lane and differ only in destination
	wire grp_acc_src    = is_ld_m | is_ld_x | is_retv;
	wire grp_to_acc_rot = is_rla | is_rotate_left_via_carry_to_acc | is_rra | is_rotate_right_via_carry_to_acc;
	wire grp_to_mem_rot = is_rl | is_rlc | is_rr | is_rrc;
	wire grp_via_carry  = is_rlc | is_rotate_left_via_carry_to_acc | is_rrc | is_rotate_right_via_carry_to_acc;
	wire grp_or         = is_or_m | is_or_x | is_orm;
	wire grp_sbc        = is_sbc | is_subtract_with_borrow_to_memory;
	wire grp_dec        = is_dsz | is_dsza;

	// ------------------------------------------------------------
	// operands and datapath
	// ------------------------------------------------------------
	wire       mem_ok  = 32'(opnd) < DMEM_DEPTH;
	wire [7:0] mem_val = mem_ok ? dmem[opnd] : 8'h00;

	wire [3:0] alu_op = 4'(mie_alu_sel(opc));
	wire [7:0] alu_res;
	wire       alu_c;
	wire       alu_ac;
	wire       alu_ov;

	mie_alu u_alu (
		.op        (alu_op),
		.acc       (ACC),
		.mem       (mem_val),
		.imm       (opnd),
		.carry_in  (FLAG_C),
		.result    (alu_res),
		.carry_out (alu_c),
		.half_out  (alu_ac),
		.ov_out    (alu_ov)
	);

	wire res_zero = alu_res == 8'h00;

	// destinations; flags untouched unless named below
	wire wr_acc = take & (grp_acc_src | is_or_m | is_or_x |
		grp_to_acc_rot | is_sbc |
		is_dsza);
	// out-of-range addresses never reach the array
	wire wr_mem = take & mem_ok & (is_st_m | is_orm | grp_to_mem_rot |
		is_subtract_with_borrow_to_memory | is_dsz);
	wire upd_z  = take & (grp_or | grp_sbc);
	wire upd_c  = take & (grp_via_carry | grp_sbc);
	wire upd_av = take & grp_sbc;

	// stored value: the accumulator itself for the plain store
	wire [7:0] mem_wdata = is_st_m ? ACC : alu_res;

	// decrement that reaches zero drops the prefetched word
	wire skip = take & grp_dec & res_zero;

	// ------------------------------------------------------------
	// return stack
	// ------------------------------------------------------------
	wire [PC_WIDTH-1:0] stack_top;
	wire [SP_W-1:0]     stack_ptr;
	// pop only on a taken exit; the dummy cycle never pops
	wire                pop = take & is_exit;

	mie_stack #(
		.WIDTH (PC_WIDTH),
		.DEPTH (STACK_DEPTH)
	) u_stack (
		.clk       (CLK),
		.rstn      (RSTN),
		.push      (PUSH),
		.push_data (PUSH_PC),
		.pop       (pop),
		.top       (stack_top),
		.ptr       (stack_ptr)
	);

	// ------------------------------------------------------------
	// register port decode
	// ------------------------------------------------------------
	wire sel_acc   = ADDR == REG_ACC;
	wire sel_flags = ADDR == REG_FLAGS;
	wire sel_ctrl  = ADDR == REG_CTRL;
	wire sel_pc_lo = ADDR == REG_PC_LO;
	wire sel_pc_hi = ADDR == REG_PC_HI;
	wire sel_stat  = ADDR == REG_STATUS;

	wire bw_acc   = WR && sel_acc;
	wire bw_flags = WR && sel_flags;
	wire bw_ctrl  = WR && sel_ctrl;
	wire bw_stat  = WR && sel_stat;

	// software view of the written byte, by field
	wire sw_c       = WR_DATA[FLAG_C_BIT];
	wire sw_ac      = WR_DATA[FLAG_AC_BIT];
	wire sw_z       = WR_DATA[FLAG_Z_BIT];
	wire sw_ov      = WR_DATA[FLAG_OV_BIT];
	wire sw_gie     = WR_DATA[CTRL_GIE_BIT];
	wire sw_hold    = WR_DATA[CTRL_HOLD_BIT];
	wire sw_unk_clr = WR_DATA[STAT_UNKNOWN_BIT];

	wire [15:0] pc_wide = 16'(PC);
	wire [7:0]  ctrl_rd = {6'h00, hold, GIE};
	wire [7:0]  flag_rd = {4'h0, FLAG_OV, FLAG_Z, FLAG_AC, FLAG_C};
	wire [7:0]  stat_rd = {unknown, 2'b00, DISCARD, 4'(stack_ptr)};

	// unmapped offsets read zero; writes there are dropped
	wire [7:0] rd_mux =
		sel_acc   ? ACC :
		sel_flags ? flag_rd :
		sel_ctrl  ? ctrl_rd :
		sel_pc_lo ? pc_wide[7:0] :
		sel_pc_hi ? pc_wide[15:8] :
		sel_stat  ? stat_rd : 8'h00;

	// ------------------------------------------------------------
	// next values
	// ------------------------------------------------------------
	// instruction results win over a software write in the same cycle
	wire [7:0] next_acc = wr_acc ? alu_res :
		bw_acc ? WR_DATA : ACC;
	wire next_c  = upd_c ? alu_c :
		bw_flags ? sw_c : FLAG_C;
	wire next_ac = upd_av ? alu_ac :
		bw_flags ? sw_ac : FLAG_AC;
	wire next_ov = upd_av ? alu_ov :
		bw_flags ? sw_ov : FLAG_OV;
	wire next_z  = upd_z ? res_zero :
		bw_flags ? sw_z : FLAG_Z;

	// hardware set beats a software clear
	wire next_gie = (take & is_interrupt_exit) |
		(bw_ctrl ? sw_gie : GIE);
	wire next_hold = bw_ctrl ? sw_hold : hold;
	wire next_unknown = (take & !is_known) |
		(unknown & !(bw_stat & sw_unk_clr));

	// counter: pop on exits, else one step; skip steps again in dummy
	wire [PC_WIDTH-1:0] pc_inc  = PC + PC_WIDTH'(1);
	// a dropped prefetch still costs one counter step
	wire pc_skip_step = (state == ST_DUMMY) && skip_pending;
	wire [PC_WIDTH-1:0] next_pc =
		pop ? stack_top :
		(take | pc_skip_step) ? pc_inc : PC;

	// ready comes from the next state so the output stays a flop
	wire next_ready   = (next_state == ST_EXEC) && !next_hold;
	wire next_discard = next_state == ST_DUMMY;

	always_comb begin
		next_state = state;
		case (state)
		ST_EXEC: begin
			if (pop || skip)
				next_state = ST_DUMMY;
		end
		ST_DUMMY: next_state = ST_EXEC;
		default:  next_state = ST_EXEC;
		endcase
	end

	// ------------------------------------------------------------
	// sequencing registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state        <= ST_EXEC;
			skip_pending <= 1'b0;
			hold         <= RST_HOLD;
		end else begin
			state        <= next_state;
			skip_pending <= skip;
			hold         <= next_hold;
		end
	end

	// counter and feed strobes move with the sequencer
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			READY   <= 1'b0;
			DISCARD <= 1'b0;
			PC      <= '0;
		end else begin
			READY   <= next_ready;
			DISCARD <= next_discard;
			PC      <= next_pc;
		end
	end

	// ------------------------------------------------------------
	// architectural registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			ACC <= RST_ACC;
		else
			ACC <= next_acc;
	end

	// flags move only where the group's rule names them
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			FLAG_C  <= RST_FLAG;
			FLAG_AC <= RST_FLAG;
			FLAG_Z  <= RST_FLAG;
			FLAG_OV <= RST_FLAG;
		end else begin
			FLAG_C  <= next_c;
			FLAG_AC <= next_ac;
			FLAG_Z  <= next_z;
			FLAG_OV <= next_ov;
		end
	end

	// interrupt enable and sticky status
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			GIE     <= RST_GIE;
			unknown <= 1'b0;
		end else begin
			GIE     <= next_gie;
			unknown <= next_unknown;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			RD_DATA <= 8'h00;
		else
			RD_DATA <= RD ? rd_mux : 8'h00;
	end

	// ------------------------------------------------------------
	// data memory
	// ------------------------------------------------------------
	// no reset on the array: contents are undefined until written
	always_ff @(posedge CLK) begin
		if (wr_mem)
			dmem[opnd] <= mem_wdata;
	end

endmodule // mie_exec
`default_nettype wire

/* File: logic/mie_pkg.sv */
`default_nettype none
package mie_pkg;

	// ------------------------------------------------------------
	// register port offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_ACC    = 8'h00;
	localparam logic [7:0] REG_FLAGS  = 8'h01;
	localparam logic [7:0] REG_CTRL   = 8'h02;
	localparam logic [7:0] REG_PC_LO  = 8'h03;
	localparam logic [7:0] REG_PC_HI  = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h05;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FLAG_C_BIT       = 0;
	localparam int FLAG_AC_BIT      = 1;
	localparam int FLAG_Z_BIT       = 2;
	localparam int FLAG_OV_BIT      = 3;
	localparam int CTRL_GIE_BIT     = 0;
	localparam int CTRL_HOLD_BIT    = 1;
	localparam int STAT_DISCARD_BIT = 4;
	localparam int STAT_UNKNOWN_BIT = 7;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ACC   = 8'h00;
	localparam logic       RST_FLAG  = 1'b0;
	localparam logic       RST_GIE   = 1'b0;
	localparam logic       RST_HOLD  = 1'b0;

	// ------------------------------------------------------------
	// cycle counts
	// ------------------------------------------------------------
	localparam int CYC_SINGLE = 1;
	localparam int CYC_DOUBLE = 2;

	// ------------------------------------------------------------
	// opcode field, high byte of the instruction word
	// ------------------------------------------------------------
	localparam logic [7:0] OP_NO_OPERATION        = 8'h00;
	localparam logic [7:0] OP_COPY_MEM_TO_ACC     = 8'h01;
	localparam logic [7:0] OP_COPY_IMM_TO_ACC     = 8'h02;
	localparam logic [7:0] OP_COPY_ACC_TO_MEM     = 8'h03;
	localparam logic [7:0] OP_DISJ_MEM_TO_ACC     = 8'h04;
	localparam logic [7:0] OP_DISJ_IMM_TO_ACC     = 8'h05;
	localparam logic [7:0] OP_DISJ_TO_MEMORY      = 8'h06;
	localparam logic [7:0] OP_SUBROUTINE_EXIT     = 8'h07;
	localparam logic [7:0] OP_EXIT_WITH_VALUE     = 8'h08;
	localparam logic [7:0] OP_INTERRUPT_EXIT      = 8'h09;
	localparam logic [7:0] OP_ROTATE_LEFT_IN_PLACE  = 8'h0A;
	localparam logic [7:0] OP_ROTATE_LEFT_TO_ACC    = 8'h0B;
	localparam logic [7:0] OP_ROTATE_LEFT_VIA_CARRY = 8'h0C;
	localparam logic [7:0] OP_ROTATE_LEFT_VC_TO_ACC = 8'h0D;
	localparam logic [7:0] OP_ROTATE_RIGHT_IN_PLACE = 8'h0E;
	localparam logic [7:0] OP_ROTATE_RIGHT_TO_ACC   = 8'h0F;
	localparam logic [7:0] OP_ROTATE_RIGHT_VIA_CARRY = 8'h10;
	localparam logic [7:0] OP_ROTATE_RIGHT_VC_TO_ACC = 8'h11;
	localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_TO_ACC    = 8'h12;
	localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_TO_MEMORY = 8'h13;
	localparam logic [7:0] OP_DECREMENT_SKIP_IF_ZERO         = 8'h14;
	localparam logic [7:0] OP_DECREMENT_SKIP_IF_ZERO_TO_ACC  = 8'h15;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ALU_PASS_MEM, ALU_PASS_IMM, ALU_PASS_ACC, ALU_OR_MEM,
		ALU_OR_IMM, ALU_ROL, ALU_ROLC, ALU_ROR, ALU_RORC,
		ALU_SBC, ALU_DEC
	} mie_alu_op_t;

	typedef enum logic {ST_EXEC, ST_DUMMY} mie_state_t;

	function automatic mie_alu_op_t mie_alu_sel(input logic [7:0] opc);
		case (opc)
		OP_COPY_MEM_TO_ACC:                mie_alu_sel = ALU_PASS_MEM;
		OP_COPY_IMM_TO_ACC,
		OP_EXIT_WITH_VALUE:                mie_alu_sel = ALU_PASS_IMM;
		OP_DISJ_MEM_TO_ACC,
		OP_DISJ_TO_MEMORY:                 mie_alu_sel = ALU_OR_MEM;
		OP_DISJ_IMM_TO_ACC:                mie_alu_sel = ALU_OR_IMM;
		OP_ROTATE_LEFT_IN_PLACE,
		OP_ROTATE_LEFT_TO_ACC:             mie_alu_sel = ALU_ROL;
		OP_ROTATE_LEFT_VIA_CARRY,
		OP_ROTATE_LEFT_VC_TO_ACC:          mie_alu_sel = ALU_ROLC;
		OP_ROTATE_RIGHT_IN_PLACE,
		OP_ROTATE_RIGHT_TO_ACC:            mie_alu_sel = ALU_ROR;
		OP_ROTATE_RIGHT_VIA_CARRY,
		OP_ROTATE_RIGHT_VC_TO_ACC:         mie_alu_sel = ALU_RORC;
		OP_SUBTRACT_WITH_BORROW_TO_ACC,
		OP_SUBTRACT_WITH_BORROW_TO_MEMORY: mie_alu_sel = ALU_SBC;
		OP_DECREMENT_SKIP_IF_ZERO,
		OP_DECREMENT_SKIP_IF_ZERO_TO_ACC:  mie_alu_sel = ALU_DEC;
		default:                           mie_alu_sel = ALU_PASS_ACC;
		endcase
	endfunction

endpackage
`default_nettype wire

/* File: logic/mie_alu.sv */
`timescale 1ns/1ns
`default_nettype none
module mie_alu import mie_pkg::*; (
	// operands
	input  wire logic [3:0] op,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] mem,
	input  wire logic [7:0] imm,
	input  wire logic       carry_in,
	// results
	output logic      [7:0] result,
	output logic            carry_out,
	output logic            half_out,
	output logic            ov_out
);

	wire [4:0] sum_lo  = {1'b0, acc[3:0]} + {1'b0, ~mem[3:0]} + {4'h0, carry_in};
	wire [7:0] sum_b6  = {1'b0, acc[6:0]} + {1'b0, ~mem[6:0]} + {7'h00, carry_in};
	wire [8:0] sum_all = {1'b0, acc} + {1'b0, ~mem} + {8'h00, carry_in};

	always_comb begin
		result    = acc;
		carry_out = carry_in;
		half_out  = sum_lo[4];
		// signed overflow: carry into bit 7 differs from carry out
		ov_out    = sum_all[8] ^ sum_b6[7];
		case (mie_alu_op_t'(op))
		ALU_PASS_MEM: result = mem;
		ALU_PASS_IMM: result = imm;
		ALU_OR_MEM:   result = acc | mem;
		ALU_OR_IMM:   result = acc | imm;
		ALU_ROL:      result = {mem[6:0], mem[7]};
		ALU_ROLC: begin
			result    = {mem[6:0], carry_in};
			carry_out = mem[7];
		end
		ALU_ROR:      result = {mem[0], mem[7:1]};
		ALU_RORC: begin
			result    = {carry_in, mem[7:1]};
			carry_out = mem[0];
		end
		ALU_SBC: begin
			result    = sum_all[7:0];
			carry_out = sum_all[8];
		end
		ALU_DEC:      result = mem - 8'h01;
		default:      result = acc;
		endcase
	end

endmodule // mie_alu
`default_nettype wire

/* File: logic/mie_stack.sv */
`timescale 1ns/1ns
`default_nettype none
module mie_stack #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// push and pop
	input  wire logic                     push,
	input  wire logic [WIDTH-1:0]         push_data,
	input  wire logic                     pop,
	// state
	output logic      [WIDTH-1:0]         top,
	output logic      [$clog2(DEPTH)-1:0] ptr
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] entry [0:DEPTH-1];

	// circular like the real core: overflow overwrites the oldest entry
	wire [PW-1:0] top_idx = ptr - PW'(1);

	assign top = entry[top_idx];

	always_ff @(posedge clk) begin
		if (push)
			entry[ptr] <= push_data;
	end

	// a push in the same cycle as a pop wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ptr <= '0;
		else if (push)
			ptr <= ptr + PW'(1);
		else if (pop)
			ptr <= top_idx;
	end

endmodule // mie_stack
`default_nettype wire

/* File: bench/mie_exec_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module mie_exec_monitor import mie_pkg::*; #(
	parameter int PC_WIDTH = 13
) (
	// clock and reset
	input wire logic                CLK,
	input wire logic                RSTN,
	// observed ports
	input wire logic                INSTR_VALID,
	input wire logic [15:0]         INSTR,
	input wire logic                READY,
	input wire logic                DISCARD,
	input wire logic [PC_WIDTH-1:0] PC,
	input wire logic [7:0]          ACC,
	input wire logic                FLAG_C,
	input wire logic                FLAG_Z,
	input wire logic                GIE
);
	wire logic       take = READY && INSTR_VALID;
	wire logic [7:0] opc  = INSTR[15:8];
	wire logic       leave = take && opc inside {OP_SUBROUTINE_EXIT,
		OP_EXIT_WITH_VALUE, OP_INTERRUPT_EXIT};

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_dummy_single: assert property (DISCARD |=> !DISCARD)
		else $error("dummy cycle lasted more than one cycle");
	a_dummy_idle: assert property (DISCARD |-> !READY)
		else $error("instruction accepted during dummy cycle");
	a_nop_step: assert property (take && opc == OP_NO_OPERATION |=>
		PC == PC_WIDTH'($past(PC) + 1) && !DISCARD && $stable(ACC))
		else $error("no-operation did more than advance the counter");
	a_exit_two: assert property (leave |=> DISCARD ##1
		(READY && $stable(PC)))
		else $error("exit did not take two cycles");
	a_gie_set: assert property (take && opc == OP_INTERRUPT_EXIT |=> GIE)
		else $error("interrupt exit left enable clear");
	a_imm_load: assert property (take && opc == OP_COPY_IMM_TO_ACC |=>
		ACC == $past(INSTR[7:0]) && $stable(FLAG_Z))
		else $error("immediate not loaded into accumulator");
	a_exit_value: assert property (take && opc == OP_EXIT_WITH_VALUE |=>
		ACC == $past(INSTR[7:0]))
		else $error("exit with value lost the immediate");
	a_or_imm: assert property (take && opc == OP_DISJ_IMM_TO_ACC |=>
		ACC == ($past(ACC) | $past(INSTR[7:0])) && FLAG_Z == (ACC == 8'h00)
		&& $stable(FLAG_C))
		else $error("or with immediate wrong");
	a_rotc_bit0: assert property (take && opc == OP_ROTATE_LEFT_VC_TO_ACC
		|=> ACC[0] == $past(FLAG_C))
		else $error("old carry did not enter bit 0");

	c_skip: cover property (take && opc == OP_DECREMENT_SKIP_IF_ZERO ##1 DISCARD);
	c_int_exit: cover property (take && opc == OP_INTERRUPT_EXIT);
	c_value_exit: cover property (take && opc == OP_EXIT_WITH_VALUE);
endmodule // mie_exec_monitor
`default_nettype wire

/* File: bench/mie_exec_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module mie_exec_tb import mie_pkg::*;;
	localparam int PCW = 13;
	logic                CLK, RSTN, INSTR_VALID, PUSH, WR, RD;
	logic [15:0]         INSTR;
	logic [PCW-1:0]      PUSH_PC;
	logic [7:0]          ADDR, WR_DATA;
	wire logic           READY, DISCARD, FLAG_C, FLAG_AC, FLAG_Z, FLAG_OV, GIE;
	wire logic [PCW-1:0] PC;
	wire logic [7:0]     RD_DATA, ACC;
	int                  err_total, checks;
	int                  acc, c, h, z, v, gie, pc;
	int                  mem [8];
	int                  stk [$];

	mie_exec #(.PC_WIDTH(PCW)) u_mie_exec (
		.CLK(CLK), .RSTN(RSTN), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
		.READY(READY), .DISCARD(DISCARD), .PC(PC), .PUSH(PUSH),
		.PUSH_PC(PUSH_PC), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR(WR),
		.RD(RD), .RD_DATA(RD_DATA), .ACC(ACC), .FLAG_C(FLAG_C),
		.FLAG_AC(FLAG_AC), .FLAG_Z(FLAG_Z), .FLAG_OV(FLAG_OV), .GIE(GIE)
	);

	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		if (err_total == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic cmp(string name, int exp, logic [15:0] got);
		checks++;
		if (got !== exp[15:0]) begin
			err_total++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WR_DATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, int exp);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		cmp("rd_data", exp, RD_DATA);
	endtask

	task automatic push(int d);
		@(posedge CLK);
		PUSH <= 1'b1;
		PUSH_PC <= d[PCW-1:0];
		@(posedge CLK);
		PUSH <= 1'b0;
		stk.push_back(d);
	endtask

	// request held until a cycle with ready, then the model steps
	task automatic exec(logic [7:0] op, int x);
		int m, r, s, n, skip;
		@(posedge CLK);
		INSTR_VALID <= 1'b1;
		INSTR <= {op, x[7:0]};
		n = 0;
		do begin
			@(negedge CLK);
			n++;
		end while (READY !== 1'b1 && n < 20);
		if (READY !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
		cmp("pc", pc, PC);
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		m = mem[x & 7];
		skip = 0;
		r = 0;
		pc = (pc + 1) % (1 << PCW);
		case (op)
		8'h01: r = m;
		8'h02, 8'h08: r = x;
		8'h03: r = acc;
		8'h04, 8'h06: r = acc | m;
		8'h05: r = acc | x;
		8'h0A, 8'h0B: r = (m << 1 | m >> 7) & 255;
		8'h0C, 8'h0D: begin
			r = (m << 1 | c) & 255;
			c = m >> 7;
		end
		8'h0E, 8'h0F: r = (m >> 1 | m << 7) & 255;
		8'h10, 8'h11: begin
			r = m >> 1 | c << 7;
			c = m & 1;
		end
		8'h12, 8'h13: begin
			s = acc + (255 - m) + c;
			h = ((acc & 15) + (15 - (m & 15)) + c) >> 4;
			v = (((acc & 127) + (127 - (m & 127)) + c) >> 7) ^ (s >> 8);
			c = s >> 8;
			r = s & 255;
		end
		8'h14, 8'h15: begin
			r = (m + 255) & 255;
			skip = r == 0;
		end
		default: r = 0;
		endcase
		if (op inside {4, 5, 6, 8'h12, 8'h13}) z = r == 0;
		if (op inside {1, 2, 4, 5, 8, 8'h0B, 8'h0D, 8'h0F, 8'h11, 8'h12, 8'h15})
			acc = r;
		if (op inside {3, 6, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h13, 8'h14})
			mem[x & 7] = r;
		if (op inside {7, 8, 9}) pc = stk.pop_back();
		if (op == 9) gie = 1;
		@(negedge CLK);
		cmp("pc_take", pc, PC);
		cmp("discard", skip || op inside {7, 8, 9}, DISCARD);
		cmp("acc", acc, ACC);
		cmp("flags", v * 8 + z * 4 + h * 2 + c,
			{FLAG_OV, FLAG_Z, FLAG_AC, FLAG_C});
		cmp("gie", gie, GIE);
		pc = (pc + skip) % (1 << PCW);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int op, a, d;
		{RSTN, INSTR_VALID, PUSH, WR, RD} = '0;
		INSTR = '0;
		PUSH_PC = '0;
		ADDR = '0;
		WR_DATA = '0;
		{acc, c, h, z, v, gie, pc} = '0;
		void'($urandom(40));
		repeat (10) @(posedge CLK);
		RSTN <= 1'b1;
		rd(REG_ACC, 0);
		rd(REG_FLAGS, 0);
		rd(REG_CTRL, 0);
		wr(8'h40, 8'hFF);
		rd(8'h40, 0);
		for (int i = 0; i < 8; i++) begin
			exec(8'h02, $urandom % 256);
			exec(8'h03, i);
		end
		// a memory byte of one must skip, in both destinations
		for (int k = 8'h14; k <= 8'h15; k++) begin
			exec(8'h02, 1);
			exec(8'h03, 5);
			exec(k[7:0], 5);
			exec(8'h00, 0);
		end
		// unknown opcode: one step, sticky status bit, write one clears
		exec(8'h16, 0);
		rd(REG_STATUS, 8'h80);
		wr(REG_STATUS, 8'h80);
		rd(REG_STATUS, 0);
		// hold: a valid word must not be taken
		wr(REG_CTRL, 8'h02);
		rd(REG_CTRL, 2);
		@(posedge CLK);
		INSTR_VALID <= 1'b1;
		INSTR <= 16'h0000;
		repeat (3) @(posedge CLK);
		@(negedge CLK);
		cmp("ready_hold", 0, READY);
		cmp("pc_hold", pc, PC);
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		wr(REG_CTRL, 8'h00);
		for (int i = 0; i < 300; i++) begin
			op = $urandom % 22;
			a = op inside {2, 5, 8} ? $urandom % 256 : $urandom % 8;
			if (op inside {7, 8, 9}) push($urandom % 8192);
			if (op == 9) begin
				wr(REG_CTRL, 8'h00);
				gie = 0;
			end
			if (i % 8 == 0) begin
				d = $urandom % 16;
				wr(REG_FLAGS, d[7:0]);
				{v, z, h, c} = {d >> 3 & 1, d >> 2 & 1, d >> 1 & 1, d & 1};
				rd(REG_ACC, acc);
			end
			exec(op[7:0], a);
		end
		for (int i = 0; i < 8; i++) exec(8'h01, i);
		rd(REG_PC_LO, pc & 255);
		rd(REG_CTRL, gie);
		report_and_stop();
	end
endmodule // mie_exec_tb

bind mie_exec mie_exec_monitor #(.PC_WIDTH(PC_WIDTH)) u_mie_exec_monitor (
	.CLK(CLK), .RSTN(RSTN), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
	.READY(READY), .DISCARD(DISCARD), .PC(PC), .ACC(ACC),
	.FLAG_C(FLAG_C), .FLAG_Z(FLAG_Z), .GIE(GIE)
);
`default_nettype wire
